// >>> logic/bpvs_defs.vh
`ifndef BPVS_DEFS_VH
`define BPVS_DEFS_VH
// ----------------------------------------
// Command codes
// ----------------------------------------
`define BPVS_CMD_PGM_SETUP 8'h40
`define BPVS_CMD_PGM_VERIFY 8'hc0
`define BPVS_CMD_ERASE 8'h20
`define BPVS_CMD_ERASE_VERIFY 8'ha0
`define BPVS_CMD_RESET 8'hff
`define BPVS_DATA_ZERO 8'h00
`define BPVS_DATA_ERASED 8'hff
// ----------------------------------------
// Timing figures and counts at 25 MHz
// ----------------------------------------
`define BPVS_CLK_MHZ 25
`define BPVS_PGM_PULSE_US 10
`define BPVS_RECOVERY_US 6
`define BPVS_ERASE_PULSE_MS 10
`define BPVS_SUPPLY_SETTLE_NS 100
`define BPVS_CLK_PERIOD_NS 40
`define BPVS_PGM_PULSE_CYC (`BPVS_PGM_PULSE_US * `BPVS_CLK_MHZ)
`define BPVS_RECOVERY_CYC (`BPVS_RECOVERY_US * `BPVS_CLK_MHZ)
`define BPVS_ERASE_PULSE_CYC (`BPVS_ERASE_PULSE_MS * 1000 * `BPVS_CLK_MHZ)
`define BPVS_SETTLE_CYC ((`BPVS_SUPPLY_SETTLE_NS + `BPVS_CLK_PERIOD_NS - 1) / `BPVS_CLK_PERIOD_NS)
`define BPVS_MAX_PGM_PULSES 25
`define BPVS_MAX_ERASE_PULSES 1000
// ----------------------------------------
// Write strobe phases
// ----------------------------------------
`define BPVS_WE_SETUP_CYC 2
`define BPVS_WE_LOW_CYC 3
`define BPVS_WE_HOLD_CYC 2
`define BPVS_RD_CYC 3
`endif

// >>> logic/bpvs_bus_cycle.v
`default_nettype none
`include "bpvs_defs.vh"
// One write or read cycle on the flash pins
module bpvs_bus_cycle #(
  parameter AW = 15
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Request
  input wire start,
  input wire is_write,
  input wire [AW-1:0] addr,
  input wire [7:0] wdata,
  output reg done_q,
  output reg [7:0] rdata_q,
  // Flash pins
  output reg [AW-1:0] flash_addr_q,
  output reg [7:0] flash_dq_out_q,
  output reg flash_dq_oe_n_q,
  input wire [7:0] flash_dq_in,
  output reg flash_ce_n_q,
  output reg flash_oe_n_q,
  output reg flash_we_n_q
);
  localparam S_IDLE = 2'd0;
  localparam S_SETUP = 2'd1;
  localparam S_ACTIVE = 2'd2;
  localparam S_HOLD = 2'd3;
  reg [1:0] st_q;
  reg [3:0] cnt_q;
  reg wr_q;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= S_IDLE;
      cnt_q <= 4'h0;
      wr_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= 8'h00;
      flash_addr_q <= {AW{1'b0}};
      flash_dq_out_q <= 8'h00;
      flash_dq_oe_n_q <= 1'b1;
      flash_ce_n_q <= 1'b1;
      flash_oe_n_q <= 1'b1;
      flash_we_n_q <= 1'b1;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (start) begin
            wr_q <= is_write;
            flash_addr_q <= addr;
            flash_dq_out_q <= wdata;
            flash_dq_oe_n_q <= ~is_write;
            flash_ce_n_q <= 1'b0;
            cnt_q <= 4'h0;
            st_q <= S_SETUP;
          end
        end
        S_SETUP: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == `BPVS_WE_SETUP_CYC - 1) begin
            cnt_q <= 4'h0;
            // Address is latched by the device on this falling edge
            if (wr_q) flash_we_n_q <= 1'b0;
            else flash_oe_n_q <= 1'b0;
            st_q <= S_ACTIVE;
          end
        end
        S_ACTIVE: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == (wr_q ? `BPVS_WE_LOW_CYC - 1 : `BPVS_RD_CYC - 1)) begin
            cnt_q <= 4'h0;
            // Data latched on the rising edge of write enable
            flash_we_n_q <= 1'b1;
            flash_oe_n_q <= 1'b1;
            if (!wr_q) rdata_q <= flash_dq_in;
            st_q <= S_HOLD;
          end
        end
        S_HOLD: begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == `BPVS_WE_HOLD_CYC - 1) begin
            flash_ce_n_q <= 1'b1;
            flash_dq_oe_n_q <= 1'b1;
            done_q <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule // bpvs_bus_cycle
`default_nettype wire

// >>> logic/bpvs_sequencer.v
`default_nettype none
`include "bpvs_defs.vh"
// Overview of operation
// - Host ends every pulse with verify code
// - Wait recovery interval before verify read
// - Time program pulse, then issue verify
// - Compare; match advances, mismatch retries byte
// - At most twenty-five pulses per byte
// - Addresses may come in any order
// - Write reset code when programming done
// - Wait for supply to settle first
// - End pulse on time, never stretched
// - Erase fail: erase again, resume there
// - At most one thousand erase pulses
// - Time erase pulse, follow with verify
// - Program all zeros before erasing
// - Erase verify code carries check address
// - Abort after setup with two resets
module bpvs_sequencer #(
  parameter AW = 15,
  parameter ERASE_PULSE_CYC = `BPVS_ERASE_PULSE_CYC,
  parameter [AW-1:0] LAST_ADDR = {AW{1'b1}}
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // User commands
  input wire prog_start,
  input wire [AW-1:0] prog_addr,
  input wire [7:0] prog_data,
  input wire erase_start,
  input wire abort,
  output reg busy_q,
  output reg done_q,
  output reg fail_q,
  // Flash pins
  output reg program_supply_high_q,
  output wire [AW-1:0] flash_addr,
  output wire [7:0] flash_dq_out,
  output wire flash_dq_oe_n,
  input wire [7:0] flash_dq_in,
  output wire flash_ce_n,
  output wire flash_oe_n,
  output wire flash_we_n
);
  // ----------------------------------------
  // State codes
  // ----------------------------------------
  localparam S_IDLE = 5'd0;
  localparam S_SETTLE = 5'd1;
  localparam S_P_SETUP = 5'd2;
  localparam S_P_CMD = 5'd3;
  localparam S_P_PULSE = 5'd4;
  localparam S_P_VFY = 5'd5;
  localparam S_P_REC = 5'd6;
  localparam S_P_READ = 5'd7;
  localparam S_E_SETUP = 5'd8;
  localparam S_E_CMD = 5'd9;
  localparam S_E_PULSE = 5'd10;
  localparam S_E_VFY = 5'd11;
  localparam S_E_REC = 5'd12;
  localparam S_E_READ = 5'd13;
  localparam S_RESET1 = 5'd14;
  localparam S_RESET2 = 5'd15;
  localparam S_FINISH = 5'd16;
  // ----------------------------------------
  // Interval limits
  // ----------------------------------------
  localparam CW = 20;
  localparam [CW-1:0] SETTLE_LAST = `BPVS_SETTLE_CYC;
  localparam [CW-1:0] PULSE_LAST = `BPVS_PGM_PULSE_CYC - 1;
  localparam [CW-1:0] REC_LAST = `BPVS_RECOVERY_CYC - 1;
  localparam [CW-1:0] ERASE_LAST = ERASE_PULSE_CYC - 1;
  localparam [4:0] PGM_LIMIT = `BPVS_MAX_PGM_PULSES;
  localparam [9:0] ERASE_LIMIT = `BPVS_MAX_ERASE_PULSES;
  // ----------------------------------------
  // Sequence state and captured request
  // ----------------------------------------
  reg [4:0] st_q;
  reg [CW-1:0] tmr_q;
  reg tmr_clr;
  reg [4:0] ppls_q;
  reg [9:0] epls_q;
  reg [AW-1:0] addr_q;
  reg [7:0] data_q;
  reg zero_fill_q;
  reg fail_flag_q;
  reg issued_q;
  wire byte_match;
  wire byte_erased;
  wire at_last;
  // ----------------------------------------
  // Bus cycle engine
  // ----------------------------------------
  reg cyc_start;
  reg cyc_write;
  reg [7:0] cyc_wdata;
  wire cyc_done;
  wire [7:0] cyc_rdata;
  bpvs_bus_cycle #(
    .AW(AW)
  ) u_cycle (
    .clk(clk),
    .rstn(rstn),
    .start(cyc_start),
    .is_write(cyc_write),
    .addr(addr_q),
    .wdata(cyc_wdata),
    .done_q(cyc_done),
    .rdata_q(cyc_rdata),
    .flash_addr_q(flash_addr),
    .flash_dq_out_q(flash_dq_out),
    .flash_dq_oe_n_q(flash_dq_oe_n),
    .flash_dq_in(flash_dq_in),
    .flash_ce_n_q(flash_ce_n),
    .flash_oe_n_q(flash_oe_n),
    .flash_we_n_q(flash_we_n)
  );
  // ----------------------------------------
  // Bus cycle request per state
  // ----------------------------------------
  always @* begin
    cyc_write = 1'b1;
    cyc_wdata = `BPVS_CMD_RESET;
    case (st_q)
      S_P_SETUP: cyc_wdata = `BPVS_CMD_PGM_SETUP;
      // Address and data in one cycle
      S_P_CMD: cyc_wdata = data_q;
      S_P_VFY: cyc_wdata = `BPVS_CMD_PGM_VERIFY;
      S_E_SETUP: cyc_wdata = `BPVS_CMD_ERASE;
      S_E_CMD: cyc_wdata = `BPVS_CMD_ERASE;
      S_E_VFY: cyc_wdata = `BPVS_CMD_ERASE_VERIFY;
      S_P_READ: cyc_write = 1'b0;
      S_E_READ: cyc_write = 1'b0;
      default: cyc_wdata = `BPVS_CMD_RESET;
    endcase
    cyc_start = 1'b0;
    case (st_q)
      S_P_SETUP, S_P_CMD, S_P_VFY, S_P_READ, S_E_SETUP, S_E_CMD,
      S_E_VFY, S_E_READ, S_RESET1, S_RESET2: cyc_start = ~issued_q;
      default: cyc_start = 1'b0;
    endcase
  end
  // ----------------------------------------
  // Verify comparison
  // ----------------------------------------
  assign byte_match = (cyc_rdata == data_q);
  assign byte_erased = (cyc_rdata == `BPVS_DATA_ERASED);
  assign at_last = (addr_q == LAST_ADDR);
  // ----------------------------------------
  // Interval timer
  // ----------------------------------------
  // Cleared on entry to every timed wait
  always @* begin
    tmr_clr = 1'b0;
    case (st_q)
      S_IDLE: tmr_clr = 1'b1;
      S_P_CMD, S_P_VFY, S_E_CMD, S_E_VFY: tmr_clr = cyc_done;
      default: tmr_clr = 1'b0;
    endcase
  end
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tmr_q <= {CW{1'b0}};
    end else if (tmr_clr) begin
      tmr_q <= {CW{1'b0}};
    end else begin
      tmr_q <= tmr_q + {{(CW-1){1'b0}}, 1'b1};
    end
  end
  // ----------------------------------------
  // Sequence control
  // ----------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= S_IDLE;
      ppls_q <= 5'd0;
      epls_q <= 10'd0;
      addr_q <= {AW{1'b0}};
      data_q <= 8'h00;
      zero_fill_q <= 1'b0;
      fail_flag_q <= 1'b0;
      issued_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      program_supply_high_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (cyc_start) issued_q <= 1'b1;
      if (cyc_done) issued_q <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (prog_start || erase_start) begin
            busy_q <= 1'b1;
            fail_q <= 1'b0;
            fail_flag_q <= 1'b0;
            program_supply_high_q <= 1'b1;
            zero_fill_q <= erase_start;
            addr_q <= erase_start ? {AW{1'b0}} : prog_addr;
            data_q <= erase_start ? `BPVS_DATA_ZERO : prog_data;
            ppls_q <= 5'd0;
            epls_q <= 10'd0;
            st_q <= S_SETTLE;
          end
        end
        S_SETTLE: if (tmr_q >= SETTLE_LAST) st_q <= S_P_SETUP;
        S_P_SETUP: if (cyc_done) st_q <= abort ? S_RESET1 : S_P_CMD;
        S_P_CMD: if (cyc_done) begin
          ppls_q <= ppls_q + 5'd1;
          st_q <= S_P_PULSE;
        end
        S_P_PULSE: if (tmr_q >= PULSE_LAST) st_q <= S_P_VFY;
        S_P_VFY: if (cyc_done) begin
          st_q <= S_P_REC;
        end
        S_P_REC: if (tmr_q >= REC_LAST) st_q <= S_P_READ;
        S_P_READ: if (cyc_done) begin
          if (byte_match) begin
            if (zero_fill_q && !at_last) begin
              addr_q <= addr_q + {{(AW-1){1'b0}}, 1'b1};
              ppls_q <= 5'd0;
              st_q <= S_P_SETUP;
            end else if (zero_fill_q) begin
              zero_fill_q <= 1'b0;
              addr_q <= {AW{1'b0}};
              st_q <= S_E_SETUP;
            end else begin
              st_q <= S_RESET1;
            end
          end else if (ppls_q >= PGM_LIMIT) begin
            fail_flag_q <= 1'b1;
            st_q <= S_RESET1;
          end else begin
            st_q <= S_P_SETUP;
          end
        end
        S_E_SETUP: if (cyc_done) st_q <= abort ? S_RESET1 : S_E_CMD;
        S_E_CMD: if (cyc_done) begin
          epls_q <= epls_q + 10'd1;
          st_q <= S_E_PULSE;
        end
        S_E_PULSE: if (tmr_q >= ERASE_LAST) st_q <= S_E_VFY;
        S_E_VFY: if (cyc_done) begin
          st_q <= S_E_REC;
        end
        S_E_REC: if (tmr_q >= REC_LAST) st_q <= S_E_READ;
        S_E_READ: if (cyc_done) begin
          if (byte_erased) begin
            if (at_last) begin
              st_q <= S_RESET1;
            end else begin
              addr_q <= addr_q + {{(AW-1){1'b0}}, 1'b1};
              st_q <= S_E_VFY;
            end
          end else if (epls_q >= ERASE_LIMIT) begin
            fail_flag_q <= 1'b1;
            st_q <= S_RESET1;
          end else begin
            st_q <= S_E_SETUP;
          end
        end
        // Reset code; twice covers setup abort
        S_RESET1: if (cyc_done) st_q <= S_RESET2;
        S_RESET2: if (cyc_done) st_q <= S_FINISH;
        S_FINISH: begin
          program_supply_high_q <= 1'b0;
          busy_q <= 1'b0;
          done_q <= 1'b1;
          fail_q <= fail_flag_q;
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule // bpvs_sequencer
`default_nettype wire

// >>> verification/bpvs_seq_props.sv
`default_nettype none
// ----------------------------------------
// Pin protocol checks
// ----------------------------------------
module bpvs_seq_props #(
  parameter AW = 15
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Watched ports
  input wire logic prog_start,
  input wire logic erase_start,
  input wire logic busy_q,
  input wire logic done_q,
  input wire logic program_supply_high_q,
  input wire logic [AW-1:0] flash_addr,
  input wire logic [7:0] flash_dq_out,
  input wire logic flash_dq_oe_n,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  a_we_in_ce: assert property (!flash_we_n |-> !flash_ce_n)
    else $error("write strobe without select");
  a_no_clash: assert property (!flash_oe_n |-> flash_dq_oe_n)
    else $error("data driven during read");
  a_strobe_excl: assert property (!(!flash_we_n && !flash_oe_n))
    else $error("both strobes low");
  a_supply_first: assert property ($fell(flash_we_n) |-> program_supply_high_q && $past(program_supply_high_q, 3))
    else $error("write before supply settled");
  a_we_width: assert property ($fell(flash_we_n) |-> !flash_we_n [*3] ##1 flash_we_n)
    else $error("write strobe width");
  a_write_stable: assert property (!flash_we_n |-> $stable(flash_addr) && $stable(flash_dq_out) && !flash_dq_oe_n)
    else $error("address or data moved in write");
  a_done_pulse: assert property (done_q |=> !done_q)
    else $error("done longer than a cycle");
  a_start_busy: assert property ((prog_start || erase_start) && !busy_q && !done_q |=> busy_q)
    else $error("start not taken");
endmodule // bpvs_seq_props
`default_nettype wire

// >>> verification/bpvs_flash_model.sv
`default_nettype none
// ----------------------------------------
// Flash device behaviour
// ----------------------------------------
module bpvs_flash_model #(
  parameter AW = 4,
  parameter real ER_NS = 2000.0
) (
  // Flash pins
  input wire logic program_supply_high,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] dq_drv,
  input wire logic dq_oe_n,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  output logic [7:0] dq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:(1<<AW)-1];
  logic [7:0] d_lat;
  logic [7:0] rd;
  logic [AW-1:0] a_lat;
  int mode = 0;
  int pgm_stub = 0;
  int er_stub = 0;
  int n_pgm = 0;
  int n_er = 0;
  int viol = 0;
  realtime t_go = 0;
  realtime t_vfy = 0;
  realtime t_sup = 0;
  always @(posedge program_supply_high) t_sup = $realtime;
  always @(negedge we_n) if (!ce_n) a_lat = addr;
  always @(posedge we_n) if (!ce_n) begin
    if ($realtime - t_sup < 100.0) viol++;
    case (mode)
      1: begin
        d_lat = dq_drv;
        t_go = $realtime;
        mode = 2;
        if (d_lat != 8'hff) n_pgm++;
        if (program_supply_high && pgm_stub == 0) mem[a_lat] = mem[a_lat] & d_lat;
        else if (pgm_stub > 0) pgm_stub--;
      end
      2: if (dq_drv == 8'hc0) begin
        if ($realtime - t_go < 10000.0 || $realtime - t_go > 11000.0) viol++;
        mode = 3;
        t_vfy = $realtime;
      end else begin
        if (!(dq_drv == 8'hff && d_lat == 8'hff)) viol++;
        mode = 0;
      end
      4: if (dq_drv == 8'h20) begin
        for (int i = 0; i < (1 << AW); i++) if (n_er == 0 && mem[i] != 8'h00) viol++;
        n_er++;
        t_go = $realtime;
        mode = 5;
        for (int i = 0; i < (1 << AW); i++) mem[i] = (er_stub > 0 && i == 2) ? 8'h00 : 8'hff;
        if (er_stub > 0) er_stub--;
      end else mode = 0;
      5: begin
        if (dq_drv != 8'ha0 || $realtime - t_go < ER_NS) viol++;
        mode = 6;
        t_vfy = $realtime;
      end
      default: begin
        if (dq_drv == 8'h40) mode = 1;
        else if (dq_drv == 8'h20) mode = 4;
        else if (dq_drv == 8'ha0 && mode == 6) t_vfy = $realtime;
        else mode = 0;
      end
    endcase
  end
  always @* begin
    rd = (mode == 3 || mode == 6) ? mem[a_lat] : mem[addr];
    if ((mode == 3 || mode == 6) && $realtime - t_vfy < 6000.0) rd = ~rd;
    if (!dq_oe_n) dq = dq_drv;
    else if (!ce_n && !oe_n) dq = rd;
    else dq = ~rd;
  end
endmodule // bpvs_flash_model
`default_nettype wire

// >>> verification/testbench.sv
`default_nettype none
// ----------------------------------------
// Sequencer bench
// ----------------------------------------
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam AW = 4;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic prog_start = 1'b0;
  logic [AW-1:0] prog_addr = 4'h0;
  logic [7:0] prog_data = 8'h00;
  logic erase_start = 1'b0;
  logic abort = 1'b0;
  wire busy_q, done_q, fail_q, sup, dq_oe_n, ce_n, oe_n, we_n;
  wire [AW-1:0] f_addr;
  wire [7:0] dq_out;
  wire [7:0] dq_in;
  int n_errors = 0;
  int total_checks = 0;
  bpvs_sequencer #(.AW(AW), .ERASE_PULSE_CYC(50), .LAST_ADDR(4'hf)) i_bpvs_sequencer (
    .clk(clk), .rstn(rstn), .prog_start(prog_start), .prog_addr(prog_addr),
    .prog_data(prog_data), .erase_start(erase_start), .abort(abort), .busy_q(busy_q),
    .done_q(done_q), .fail_q(fail_q), .program_supply_high_q(sup), .flash_addr(f_addr),
    .flash_dq_out(dq_out), .flash_dq_oe_n(dq_oe_n), .flash_dq_in(dq_in),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n));
  bpvs_flash_model #(.AW(AW), .ER_NS(2000.0)) i_bpvs_flash_model (
    .program_supply_high(sup), .addr(f_addr), .dq_drv(dq_out), .dq_oe_n(dq_oe_n),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq(dq_in));
  initial forever #20 clk = ~clk;
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic run(input logic e, input logic [AW-1:0] a, input logic [7:0] d, input logic ab);
    @(posedge clk);
    prog_start <= ~e;
    erase_start <= e;
    prog_addr <= a;
    prog_data <= d;
    abort <= ab;
    @(posedge clk);
    prog_start <= 1'b0;
    erase_start <= 1'b0;
    @(negedge clk);
    chk("busy", busy_q, 1'b1);
    chk("supply", sup, 1'b1);
    repeat (30000) begin
      @(negedge clk);
      if (done_q === 1'b1) break;
    end
    chk("done", done_q, 1'b1);
    chk("idle", busy_q, 1'b0);
    chk("supply off", sup, 1'b0);
  endtask
  task automatic t_prog;
    run(1'b0, 4'h2, 8'ha5, 1'b0);
    run(1'b0, 4'h0, 8'h3c, 1'b0);
    chk("mem2", i_bpvs_flash_model.mem[2], 8'ha5);
    chk("mem0", i_bpvs_flash_model.mem[0], 8'h3c);
    chk("pulses", i_bpvs_flash_model.n_pgm, 16'd2);
    chk("fail", fail_q, 1'b0);
    chk("mode", i_bpvs_flash_model.mode, 16'd0);
  endtask
  task automatic t_retry;
    i_bpvs_flash_model.n_pgm = 0;
    i_bpvs_flash_model.pgm_stub = 2;
    run(1'b0, 4'h1, 8'h0f, 1'b0);
    chk("pulses", i_bpvs_flash_model.n_pgm, 16'd3);
    chk("mem1", i_bpvs_flash_model.mem[1], 8'h0f);
    chk("fail", fail_q, 1'b0);
  endtask
  task automatic t_exhaust;
    i_bpvs_flash_model.n_pgm = 0;
    i_bpvs_flash_model.pgm_stub = 40;
    run(1'b0, 4'h3, 8'h00, 1'b0);
    chk("pulses", i_bpvs_flash_model.n_pgm, 16'd25);
    chk("fail", fail_q, 1'b1);
    i_bpvs_flash_model.pgm_stub = 0;
  endtask
  task automatic t_abort;
    i_bpvs_flash_model.n_pgm = 0;
    run(1'b0, 4'h3, 8'h12, 1'b1);
    chk("mem3", i_bpvs_flash_model.mem[3], 8'hff);
    chk("pulses", i_bpvs_flash_model.n_pgm, 16'd0);
    chk("mode", i_bpvs_flash_model.mode, 16'd0);
  endtask
  task automatic t_erase;
    i_bpvs_flash_model.n_er = 0;
    i_bpvs_flash_model.er_stub = 1;
    run(1'b1, 4'h0, 8'h00, 1'b0);
    chk("erases", i_bpvs_flash_model.n_er, 16'd2);
    for (int i = 0; i < 16; i++) chk("erased", i_bpvs_flash_model.mem[i], 8'hff);
    chk("fail", fail_q, 1'b0);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 16; i++) i_bpvs_flash_model.mem[i] = 8'hff;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_prog();
    t_retry();
    t_exhaust();
    t_abort();
    t_erase();
    chk("protocol", i_bpvs_flash_model.viol, 16'd0);
    close_out();
  end
  initial begin
    repeat (50000) @(posedge clk);
    n_errors++;
    close_out();
  end
endmodule // testbench
bind bpvs_sequencer bpvs_seq_props #(.AW(AW)) i_bpvs_seq_props (
  .clk(clk), .rstn(rstn), .prog_start(prog_start), .erase_start(erase_start),
  .busy_q(busy_q), .done_q(done_q), .program_supply_high_q(program_supply_high_q),
  .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n),
  .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));
`default_nettype wire
